// ==== include/mmtimer_consts.vh ====
// constants for the multi-mode timer channel
`ifndef MMTIMER_CONSTS_VH
`define MMTIMER_CONSTS_VH

// register offsets (word index on the plain port)
`define REG_CTRL        4'h0
`define REG_COUNT       4'h1
`define REG_RELOAD      4'h2
`define REG_STATUS      4'h3
`define REG_MASK        4'h4

// control register fields
`define CTRL_START_BIT  0
`define CTRL_MODE_LO    1
`define CTRL_MODE_HI    2
`define CTRL_UP_BIT     3
`define CTRL_FREE_BIT   4
`define CTRL_TRIG_BIT   5

// operation modes
`define MODE_TIMER      2'h0
`define MODE_EVENT      2'h1
`define MODE_ONESHOT    2'h2
`define MODE_PWM        2'h3

// status bits
`define ST_IRQ_BIT      0
`define ST_RELOAD_BIT   1

// reset values and count constants
`define CNT_RESET       16'h0000
`define CNT_ONES        16'hFFFF
`define CNT_ZERO        16'h0000
`define CTRL_RESET      6'h00
`define ST_RESET        2'h0
`define ONE16           16'h0001

`endif

// ==== hw/edge_sync.v ====
// two flip-flop synchroniser with rising edge pulse for the event and trigger pins
module edge_sync (
    input  wire core_clk_i,
    input  wire reset_n_i,
    input  wire async_i,
    output wire rise_o
);
    reg meta_ff;
    reg sync_ff;
    reg last_ff;

    // first stage read only by the second stage
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            last_ff <= 1'b0;
        end else begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end

    assign rise_o = sync_ff & ~last_ff;
endmodule // edge_sync

// ==== hw/mmtimer.v ====
// multi-mode 16-bit timer channel with register port and interrupt
`include "mmtimer_consts.vh"
module mmtimer #(
    parameter CNT_W = 16
) (
    input  wire             core_clk_i,
    input  wire             reset_n_i,
    input  wire [3:0]       addr_i,
    input  wire [15:0]      wdata_i,
    input  wire             wr_i,
    input  wire             rd_i,
    output reg  [15:0]      rdata_o,
    input  wire             event_in_i,
    input  wire             trigger_in_i,
    output wire             channel_output_pin_o,
    output wire             irq_o
);
    // *****************************************************
    // state
    // *****************************************************
    reg [5:0]       ctrl_ff;
    reg [CNT_W-1:0] count_ff;
    reg [CNT_W-1:0] reload_ff;
    reg [1:0]       status_ff;
    reg [1:0]       mask_ff;
    reg             out_ff;
    reg             reload_evt_ff;  // reload happened in the previous cycle
    reg             underflow_ff;   // direction of that reload
    reg             pwm_phase_ff;   // 1 while pwm high phase counts
    reg             os_run_ff;      // one-shot count active
    reg             first_mode_ff;  // no mode picked since reset

    wire            ev_rise;
    wire            trig_rise;
    wire            start;
    wire [1:0]      mode;
    wire            up;
    wire            ctrl_wr;
    wire [1:0]      nxt_mode;
    wire            nxt_start;

    edge_sync u_ev (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .async_i    (event_in_i),
        .rise_o     (ev_rise)
    );
    edge_sync u_tr (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .async_i    (trigger_in_i),
        .rise_o     (trig_rise)
    );

    assign start     = ctrl_ff[`CTRL_START_BIT];
    assign mode      = ctrl_ff[`CTRL_MODE_HI:`CTRL_MODE_LO];
    assign up        = ctrl_ff[`CTRL_UP_BIT];
    assign ctrl_wr   = wr_i && (addr_i == `REG_CTRL);
    assign nxt_mode  = wdata_i[`CTRL_MODE_HI:`CTRL_MODE_LO];
    assign nxt_start = wdata_i[`CTRL_START_BIT];

    // *****************************************************
    // count tick and terminal detection
    // *****************************************************
    wire tick = (mode == `MODE_EVENT) ? ev_rise : 1'b1;
    wire cnt_up = (mode == `MODE_EVENT) && up;
    wire at_zero = (count_ff == `CNT_ZERO);
    wire at_ones = (count_ff == `CNT_ONES);
    wire term = cnt_up ? at_ones : at_zero;
    wire free = ctrl_ff[`CTRL_FREE_BIT];
    wire counting = start && ((mode == `MODE_ONESHOT) ? os_run_ff : 1'b1);
    wire expire = counting && tick && term;

    // abort events: start flag cleared while running
    wire stop_wr  = ctrl_wr && start && !nxt_start;
    wire os_abort = stop_wr && (mode == `MODE_ONESHOT) && os_run_ff;
    wire pwm_stop = stop_wr && (mode == `MODE_PWM);
    // entry into one-shot or pwm from timer/event, or first after reset
    wire into_irq_mode = ctrl_wr && nxt_mode[1] &&
                         (first_mode_ff || !mode[1]);

    // hardware request events, any one sets the sticky bit
    wire irq_evt = os_abort ||
                   (pwm_stop && out_ff) ||
                   into_irq_mode ||
                   (expire && (mode != `MODE_PWM || pwm_phase_ff));

    // *****************************************************
    // control register and mode tracking
    // *****************************************************
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_ff       <= `CTRL_RESET;
            first_mode_ff <= 1'b1;
        end else if (ctrl_wr) begin
            ctrl_ff       <= wdata_i[5:0];
            first_mode_ff <= 1'b0;
        end
    end

    // *****************************************************
    // counter, reload and output
    // *****************************************************
    // software is expected to rewrite count before free-run restart
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count_ff      <= `CNT_RESET;
            reload_ff     <= `CNT_RESET;
            out_ff        <= 1'b0;
            reload_evt_ff <= 1'b0;
            underflow_ff  <= 1'b0;
            pwm_phase_ff  <= 1'b0;
            os_run_ff     <= 1'b0;
        end else begin
            reload_evt_ff <= 1'b0;
            if (wr_i && addr_i == `REG_RELOAD) begin
                reload_ff <= wdata_i;
            end
            if (os_abort) begin
                count_ff  <= reload_ff;
                os_run_ff <= 1'b0;
                out_ff    <= 1'b0;
            end else if (pwm_stop) begin
                out_ff       <= 1'b0;
                pwm_phase_ff <= 1'b0;
            end else if (wr_i && addr_i == `REG_COUNT) begin
                count_ff  <= wdata_i;
                reload_ff <= wdata_i;
            end else if (mode == `MODE_ONESHOT && start && !os_run_ff &&
                         trig_rise) begin
                os_run_ff <= 1'b1;
                out_ff    <= 1'b1;
                count_ff  <= reload_ff;
            end else if (mode == `MODE_PWM && start && !pwm_phase_ff &&
                         at_zero) begin
                pwm_phase_ff <= 1'b1;
                out_ff       <= 1'b1;
                count_ff     <= reload_ff;
            end else if (expire) begin
                reload_evt_ff <= 1'b1;
                underflow_ff  <= !cnt_up;
                count_ff      <= (mode == `MODE_EVENT && free) ?
                                 (cnt_up ? `CNT_ZERO : `CNT_ONES) :
                                 reload_ff;
                if (mode == `MODE_ONESHOT) begin
                    os_run_ff <= 1'b0;
                    out_ff    <= 1'b0;
                end else if (mode == `MODE_PWM) begin
                    pwm_phase_ff <= 1'b0;
                    out_ff       <= 1'b0;
                    count_ff     <= `CNT_ONES - reload_ff;
                end
            end else if (counting && tick) begin
                count_ff <= cnt_up ? count_ff + `ONE16 :
                                     count_ff - `ONE16;
            end
        end
    end

    // *****************************************************
    // interrupt status and mask
    // *****************************************************
    // sticky until cleared
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            status_ff <= `ST_RESET;
            mask_ff   <= `ST_RESET;
        end else begin
            if (wr_i && addr_i == `REG_MASK) begin
                mask_ff <= wdata_i[1:0];
            end
            // irq_evt sets the request bit, expire sets the reload bit; set wins over clear
            status_ff[`ST_IRQ_BIT] <= irq_evt ||
                (status_ff[`ST_IRQ_BIT] &&
                 !(wr_i && addr_i == `REG_STATUS &&
                   wdata_i[`ST_IRQ_BIT]));
            status_ff[`ST_RELOAD_BIT] <= expire ||
                (status_ff[`ST_RELOAD_BIT] &&
                 !(wr_i && addr_i == `REG_STATUS &&
                   wdata_i[`ST_RELOAD_BIT]));
        end
    end

    // *****************************************************
    // read port, data valid one cycle after strobe
    // *****************************************************
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_o <= `CNT_ZERO;
        end else if (rd_i) begin
            case (addr_i)
                `REG_CTRL:   rdata_o <= {10'h000, ctrl_ff};
                `REG_COUNT:  rdata_o <= (reload_evt_ff &&
                                         mode == `MODE_EVENT) ?
                                        (underflow_ff ? `CNT_ONES :
                                                        `CNT_ZERO) :
                                        count_ff;
                `REG_RELOAD: rdata_o <= reload_ff;
                `REG_STATUS: rdata_o <= {14'h0000, status_ff};
                `REG_MASK:   rdata_o <= {14'h0000, mask_ff};
                default:     rdata_o <= `CNT_ZERO;
            endcase
        end else begin
            rdata_o <= `CNT_ZERO;
        end
    end

    assign channel_output_pin_o = out_ff;
    assign irq_o = |(status_ff & mask_ff);
endmodule // mmtimer

// ==== dv/mmtimer_asserts.sv ====
// port-level assertions for the multi-mode timer channel
module mmtimer_asserts #(
    parameter CNT_W = 16
) (
    input wire        core_clk_i,
    input wire        reset_n_i,
    input wire [3:0]  addr_i,
    input wire [15:0] wdata_i,
    input wire        wr_i,
    input wire        rd_i,
    input wire [15:0] rdata_o,
    input wire        event_in_i,
    input wire        trigger_in_i,
    input wire        channel_output_pin_o,
    input wire        irq_o
);
    logic        start_ff;
    logic [1:0]  mode_ff;
    logic [1:0]  mask_ff;
    logic [15:0] reload_ff;
    wire         ctl_w;
    wire         stop_w;
    assign ctl_w = wr_i && addr_i == 4'h0;
    // a stop keeps the mode and clears only the start flag
    assign stop_w = ctl_w && start_ff && !wdata_i[0] && wdata_i[2:1] == mode_ff;
    // shadows of what software wrote, so no internal probe is needed
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            start_ff <= 1'b0;
            mode_ff <= 2'h0;
            mask_ff <= 2'h0;
            reload_ff <= 16'h0000;
        end else begin
            if (ctl_w) start_ff <= wdata_i[0];
            if (ctl_w) mode_ff <= wdata_i[2:1];
            if (wr_i && addr_i == 4'h4) mask_ff <= wdata_i[1:0];
            if (wr_i && addr_i[3:1] == 3'h0 && addr_i[0]) reload_ff <= wdata_i;
            if (wr_i && addr_i == 4'h2) reload_ff <= wdata_i;
        end
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    // pin high marks a one-shot count in progress
    sequence os_stop;
        stop_w && mode_ff == 2'h2 && channel_output_pin_o;
    endsequence
    sequence pwm_stop; stop_w && mode_ff == 2'h3; endsequence
    sequence cnt_rd; rd_i && addr_i == 4'h1; endsequence
    sequence live_pair;
        (cnt_rd and (start_ff && mode_ff == 2'h0 && !wr_i)) ##1 !wr_i ##1 cnt_rd;
    endsequence
    live_read_a: assert property (live_pair |=> $past(rdata_o, 2) < 16'h0002
        || rdata_o == $past(rdata_o, 2) - 16'h0002) else $error("count not live");
    halted_read_a: assert property ((wr_i && addr_i == 4'h1 && !start_ff)
        ##1 !wr_i ##1 cnt_rd |=> rdata_o == $past(wdata_i, 3))
        else $error("halted count read back differs");
    abort_reload_a: assert property (os_stop ##1 !wr_i ##1 cnt_rd
        |=> rdata_o == reload_ff) else $error("abort did not reload count");
    abort_pin_a: assert property (os_stop |=> !channel_output_pin_o)
        else $error("pin high after one-shot abort");
    abort_irq_a: assert property (os_stop and mask_ff[0] |=> irq_o)
        else $error("no request after one-shot abort");
    oneshot_entry_a: assert property (ctl_w && wdata_i[2:1] == 2'h2
        && !mode_ff[1] && mask_ff[0] |=> irq_o) else $error("no one-shot entry irq");
    pwm_entry_a: assert property (ctl_w && wdata_i[2:1] == 2'h3
        && !mode_ff[1] && mask_ff[0] |=> irq_o) else $error("no pwm entry irq");
    pwm_stop_high_a: assert property ((pwm_stop and channel_output_pin_o
        && mask_ff[0]) |=> !channel_output_pin_o && irq_o)
        else $error("pwm stop from high wrong");
    pwm_stop_low_a: assert property ((pwm_stop and !channel_output_pin_o
        && !irq_o && mask_ff == 2'h1) |=> !channel_output_pin_o && !irq_o)
        else $error("pwm stop from low wrong");
    irq_sticky_a: assert property (irq_o && !(wr_i && addr_i[3:2] != 2'h0
        || wr_i && addr_i == 4'h3) |=> irq_o) else $error("request dropped alone");
endmodule // mmtimer_asserts

bind mmtimer mmtimer_asserts #(.CNT_W(CNT_W)) i_chk (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .event_in_i(event_in_i), .trigger_in_i(trigger_in_i),
    .channel_output_pin_o(channel_output_pin_o), .irq_o(irq_o));

// ==== dv/testbench.sv ====
// self-checking bench for the multi-mode timer channel
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic [3:0]  addr_i = 4'h0;
    logic [15:0] wdata_i = 16'h0000;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        trigger_in_i = 1'b0;
    logic        event_in_i = 1'b0;
    logic [15:0] rdata_o;
    logic [15:0] r;
    logic [15:0] v;
    logic        pin;
    logic        irq_o;
    int          errors = 0;
    int          num_checks = 0;
    int          n;
    mmtimer i_dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .event_in_i(event_in_i),
        .trigger_in_i(trigger_in_i),
        .channel_output_pin_o(pin), .irq_o(irq_o));
    // one-cycle write, then 1 ns so its effect has landed
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge core_clk_i);
        wr_i <= 1'b0;
        #1;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge core_clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge core_clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    task automatic chkb(input logic got, input logic exp);
        chk({15'h0000, got}, {15'h0000, exp});
    endtask
    task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
        rd(a, v);
        chk(v, exp);
    endtask
    // bounded wait for a pin level; running out shows as a mismatch
    task automatic wait_pin(input logic lvl);
        for (n = 0; n < 20000 && pin !== lvl; n++) @(posedge core_clk_i);
        #1;
        chkb(pin, lvl);
    endtask
    task automatic print_verdict;
        if (errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        forever #5 core_clk_i = ~core_clk_i;
    end
    // watchdog well beyond the short pwm phases the tests wait for
    initial begin
        #900_000;
        errors++;
        print_verdict();
    end
    initial begin
        r = $urandom(49850);
        repeat (12) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        rdc(4'h0, 16'h0000);
        rdc(4'h3, 16'h0000);
        rdc(4'h4, 16'h0000);
        wr(4'h9, 16'hFFFF);
        rdc(4'h9, 16'h0000);
        wr(4'h4, 16'h0001);
        wr(4'h0, 16'h0004);
        chkb(irq_o, 1'b1);
        wr(4'h4, 16'h0000);
        chkb(irq_o, 1'b0);
        wr(4'h4, 16'h0001);
        chkb(irq_o, 1'b1);
        wr(4'h3, 16'h0001);
        chkb(irq_o, 1'b0);
        wr(4'h0, 16'h0000);
        // halted writes, random and the all-ones corner
        for (int i = 0; i < 4; i++) begin
            r = (i == 3) ? 16'hFFFF : 16'($urandom);
            wr(4'h1, r);
            rdc(4'h1, r);
        end
        wr(4'h0, 16'h0006);
        chkb(irq_o, 1'b1);
        wr(4'h3, 16'h0001);
        wr(4'h0, 16'h0013);
        wr(4'h0, 16'h0012);
        wr(4'h1, r);
        wr(4'h0, 16'h0004);
        chkb(irq_o, 1'b1);
        wr(4'h3, 16'h0001);
        // one-shot aborted in mid-count
        r = 16'h0100 | 16'($urandom & 32'h0FFF);
        wr(4'h1, r);
        wr(4'h0, 16'h0005);
        @(posedge core_clk_i) trigger_in_i <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        trigger_in_i <= 1'b0;
        wait_pin(1'b1);
        wr(4'h0, 16'h0004);
        chkb(pin, 1'b0);
        chkb(irq_o, 1'b1);
        rdc(4'h1, r);
        wr(4'h3, 16'h0001);
        wr(4'h0, 16'h0001);
        rd(4'h1, r);
        rdc(4'h1, r - 16'h0002);
        // event mode reload read: down from zero, then up from all ones
        for (int i = 0; i < 2; i++) begin
            wr(4'h1, (i == 0) ? 16'h0000 : 16'hFFFF);
            wr(4'h0, (i == 0) ? 16'h0003 : 16'h000B);
            @(posedge core_clk_i) event_in_i <= 1'b1;
            // pin edge reaches the counter three edges later
            repeat (3) @(posedge core_clk_i);
            rd_i <= 1'b1;
            addr_i <= 4'h1;
            @(posedge core_clk_i);
            rd_i <= 1'b0;
            event_in_i <= 1'b0;
            #1;
            chk(rdata_o, (i == 0) ? 16'hFFFF : 16'h0000);
        end
        wr(4'h0, 16'h0006);
        wr(4'h3, 16'h0001);
        // short high phase, long low phase
        wr(4'h1, 16'h0020);
        wr(4'h0, 16'h0007);
        wait_pin(1'b1);
        wr(4'h0, 16'h0006);
        chkb(pin, 1'b0);
        chkb(irq_o, 1'b1);
        wr(4'h3, 16'h0001);
        wr(4'h0, 16'h0007);
        wait_pin(1'b1);
        wait_pin(1'b0);
        // end of the high phase raised a request; clear it first
        wr(4'h3, 16'h0001);
        wr(4'h0, 16'h0006);
        chkb(pin, 1'b0);
        chkb(irq_o, 1'b0);
        print_verdict();
    end
endmodule // testbench
